/* File: hw/modem_cmd_pkg.sv */
/*
  shared constants and types for the modem configuration command decoder.
  assumes one 200 MHz clock and an apb master on the register side.
*/
`default_nettype none
package modem_cmd_pkg;
  localparam logic [7:0]  OP_AFE_WRITE    = 8'h07;
  localparam logic [7:0]  OP_FSK_CFG      = 8'h1d;
  localparam logic [7:0]  OP_V22_CFG      = 8'h1e;
  // register byte addresses
  localparam logic [11:0] ADDR_CMD        = 12'h000;
  localparam logic [11:0] ADDR_STATUS     = 12'h004;
  localparam logic [11:0] ADDR_FSK        = 12'h008;
  localparam logic [11:0] ADDR_V22        = 12'h00c;
  localparam logic [11:0] ADDR_AFE_LAST   = 12'h010;
  // field positions
  localparam int          REG_CODE_LSB    = 5;
  localparam int          LOOPBACK_BIT    = 3;
  localparam int          STD_HI_BIT      = 2;
  localparam int          STD_LO_BIT      = 1;
  localparam int          ORIG_BIT        = 0;
  localparam int          ATTN_LSB        = 4;
  localparam int          LL_BIT          = 1;
  // reset values
  localparam logic [7:0]  FSK_P1_RST      = 8'h00;
  localparam logic [7:0]  FSK_P2_RST      = 8'h00;
  localparam logic [7:0]  V22_P1_RST      = 8'h00;
  localparam logic [1:0]  V22_MODE_V22BIS = 2'h0;

  typedef enum logic [2:0] {
    MODE_IDLE, MODE_FSK, MODE_V22BIS, MODE_V22, MODE_V22_600, MODE_BELL212
  } line_mode_t;

  typedef struct packed {
    logic [2:0] regCode;
    logic [7:0] data;
  } afe_write_t;

  typedef struct packed {
    logic       analogLoopbackEnable;
    logic       standardSelectHi;
    logic       standardSelectLo;
    logic       originate;
    logic [3:0] txAttenuationField;
    logic       leasedLineThresholdSelect;
  } fsk_cfg_t;
endpackage : modem_cmd_pkg
`default_nettype wire

/* File: hw/modem_config_command_decoder.sv */
/*
  byte command decoder: host writes opcode and parameter bytes through apb,
  the block forwards front-end writes and latches line mode settings.
  assumes the front end accepts one write per afeValid pulse.
*/
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - front-end write: opcode, register code, data
// - forward data bytes unchanged, arrival order
// - opcode 1d selects fsk mode
// - fsk byte one: loopback, standard, originate
// - fsk byte two: attenuation, leased threshold
// - opcode 1e enters v22bis family
// - mode bits pick v22bis, v22, 600, 212a
module modem_config_command_decoder
  import modem_cmd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  afe_write_t  afeWrite,
  output var  logic        afeValid,
  output var  line_mode_t  lineMode,
  output var  fsk_cfg_t    fskCfg,
  output var  logic        cmdError
);
  typedef enum logic [1:0] {WAIT_OP, WAIT_P1, WAIT_P2} parse_t;

  parse_t      state_q;
  parse_t      state_d;
  logic [7:0]  opcode_q;
  logic [7:0]  p1_q;
  logic [7:0]  fskP1_q;
  logic [7:0]  fskP2_q;
  logic [7:0]  v22P1_q;
  logic [7:0]  afeLast_q;
  line_mode_t  mode_q;
  logic        err_q;

  wire         apbAccess = psel && penable;
  wire         byteWrite = apbAccess && pwrite && (paddr == ADDR_CMD);
  wire  [7:0]  cmdByte   = pwdata[7:0];
  wire         addrHit   = (paddr == ADDR_CMD) || (paddr == ADDR_STATUS) ||
                           (paddr == ADDR_FSK) || (paddr == ADDR_V22) ||
                           (paddr == ADDR_AFE_LAST);
  wire         knownOp   = (cmdByte == OP_AFE_WRITE) || (cmdByte == OP_FSK_CFG) ||
                           (cmdByte == OP_V22_CFG);
  // afe write takes two bytes; fsk two; v22 one here
  wire         lastByte  = (state_q == WAIT_P2) ||
                           ((state_q == WAIT_P1) && (opcode_q == OP_V22_CFG));
  // mode bits choose the v22 family member
  wire  [1:0]  v22Bits   = cmdByte[STD_HI_BIT:STD_LO_BIT];
  line_mode_t  v22Mode;

  // one strobe per parser step keeps the flop blocks short
  wire         opcodeTake = byteWrite && (state_q == WAIT_OP);
  wire         p1Take     = byteWrite && (state_q == WAIT_P1);
  wire         p2Take     = byteWrite && (state_q == WAIT_P2);
  // unknown opcode dropped; the parser keeps waiting for an opcode
  wire         badOpcode  = opcodeTake && !knownOp;
  // third byte of a front-end write is its data
  wire         afeDone    = p2Take && (opcode_q == OP_AFE_WRITE);
  // fsk command ends on its second parameter
  wire         fskDone    = p2Take && (opcode_q == OP_FSK_CFG);
  // v22 family command ends on its first parameter
  wire         v22Done    = p1Take && (opcode_q == OP_V22_CFG);
  // a status read clears the error flag in its access phase
  wire         statusRead = apbAccess && !pwrite && (paddr == ADDR_STATUS);
  // read data is fetched in setup, before penable rises
  wire         readSetup  = psel && !penable && !pwrite;
  logic [31:0] readWord;

  always_comb
  begin
    unique case (v22Bits)
      2'h0:    v22Mode = MODE_V22BIS;
      2'h1:    v22Mode = MODE_V22;
      2'h2:    v22Mode = MODE_V22_600;
      2'h3:    v22Mode = MODE_BELL212;
    endcase
  end

  always_comb
  begin
    state_d = state_q;
    if (byteWrite)
    begin
      unique case (state_q)
        WAIT_OP: state_d = knownOp ? WAIT_P1 : WAIT_OP;
        WAIT_P1: state_d = lastByte ? WAIT_OP : WAIT_P2;
        WAIT_P2: state_d = WAIT_OP;
        default: state_d = WAIT_OP;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q  <= WAIT_OP;
      opcode_q <= 8'h00;
      p1_q     <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if (opcodeTake)
        opcode_q <= cmdByte;
      if (p1Take)
        p1_q <= cmdByte;
    end
  end

  // data byte forwarded unchanged, one pulse per command
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      afeValid  <= 1'b0;
      afeWrite  <= '0;
      afeLast_q <= 8'h00;
    end
    else
    begin
      afeValid <= 1'b0;
      if (afeDone)
      begin
        // register code from the top three bits
        afeWrite.regCode <= p1_q[7:REG_CODE_LSB];
        afeWrite.data    <= cmdByte;
        afeLast_q        <= cmdByte;
        afeValid         <= 1'b1;
      end
    end
  end

  // settings change only when a command completes, never half way
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fskP1_q <= FSK_P1_RST;
      fskP2_q <= FSK_P2_RST;
      v22P1_q <= V22_P1_RST;
      mode_q  <= MODE_IDLE;
      err_q   <= 1'b0;
    end
    else
    begin
      // set wins over a read clear in the same cycle
      if (badOpcode)
        err_q <= 1'b1;
      else if (statusRead)
        err_q <= 1'b0;
      // fsk command completes on its second parameter
      if (fskDone)
      begin
        fskP1_q <= p1_q;
        fskP2_q <= cmdByte;
        mode_q  <= MODE_FSK;
      end
      // v22 family command enters v22bis unless bits differ
      if (v22Done)
      begin
        v22P1_q <= cmdByte;
        mode_q  <= v22Mode;
      end
    end
  end

  // first fsk byte fields; upper nibble ignored
  assign fskCfg.analogLoopbackEnable = fskP1_q[LOOPBACK_BIT];
  assign fskCfg.standardSelectHi     = fskP1_q[STD_HI_BIT];
  assign fskCfg.standardSelectLo     = fskP1_q[STD_LO_BIT];
  assign fskCfg.originate            = fskP1_q[ORIG_BIT];
  // second fsk byte fields; bits 3, 2 and 0 ignored
  assign fskCfg.txAttenuationField        = fskP2_q[7:ATTN_LSB];
  assign fskCfg.leasedLineThresholdSelect = fskP2_q[LL_BIT];
  assign lineMode = mode_q;
  assign cmdError = err_q;

  // status: error flag, line mode, parser state
  wire [31:0] statusWord = {24'h000000, 2'h0, err_q, mode_q, state_q};

  // zero wait states: every access ends one cycle after setup
  assign pready  = 1'b1;
  // unmapped access answers with an error; writes there are dropped
  assign pslverr = apbAccess && !addrHit;

  // read selection; the command register reads back as zero
  always_comb
  begin
    unique case (paddr)
      ADDR_STATUS:   readWord = statusWord;
      ADDR_FSK:      readWord = {16'h0000, fskP2_q, fskP1_q};
      ADDR_V22:      readWord = {24'h000000, v22P1_q};
      ADDR_AFE_LAST: readWord = {24'h000000, afeLast_q};
      default:       readWord = 32'h00000000;
    endcase
  end

  // loaded in setup so the word stands through the access phase
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      prdata <= 32'h00000000;
    else if (readSetup)
      prdata <= readWord;
  end
endmodule : modem_config_command_decoder
`default_nettype wire

/* File: sim/modem_cmd_chk.sv */
/* port checks of the decoder; assumes command bytes stay aligned */
`timescale 1ns/1ps
`default_nettype none
module modem_cmd_chk
  import modem_cmd_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        afeValid,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire afe_write_t  afeWrite,
  input wire line_mode_t  lineMode,
  input wire fsk_cfg_t    fskCfg
);
  logic [23:0] h_q;
  wire wr0 = psel & penable & pwrite & (paddr == ADDR_CMD);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // last three bytes only, no parser copy
  always_ff @(posedge clk)
    h_q <= sys_rst ? 24'h0 : wr0 ? {h_q[15:0], pwdata[7:0]} : h_q;
  AST_ONE: assert property (afeValid |=> !afeValid) else $error("pulse");
  AST_OP: assert property (afeValid |-> h_q[23:16] == OP_AFE_WRITE) else $error("op");
  AST_DAT: assert property (afeValid |-> afeWrite == {h_q[15:13], h_q[7:0]})
    else $error("data");
  AST_HOLD: assert property (!afeValid |-> $stable(afeWrite)) else $error("hold");
  AST_FSK: assert property ($changed(fskCfg) |-> lineMode == MODE_FSK && h_q[23:16] == OP_FSK_CFG)
    else $error("fsk");
  AST_FLD: assert property ($changed(fskCfg) |-> fskCfg == {h_q[11:8], h_q[7:4], h_q[1]})
    else $error("fields");
  AST_V22: assert property ($changed(lineMode) && lineMode != MODE_FSK |->
    h_q[15:8] == OP_V22_CFG && lineMode == 3'h2 + h_q[2:1]) else $error("v22");
  cover property (afeValid);
  cover property (lineMode == MODE_BELL212);
  cover property ($changed(fskCfg));
endmodule : modem_cmd_chk
bind modem_config_command_decoder modem_cmd_chk chk_u (.*);
`default_nettype wire

/* File: sim/afe_model.sv */
/* front-end model: logs writes; assumes one-cycle afeValid */
`timescale 1ns/1ps
`default_nettype none
module afe_model
  import modem_cmd_pkg::*;
(
  input wire logic       clk,
  input wire logic       afeValid,
  input wire afe_write_t afeWrite
);
  afe_write_t seen[$];
  always @(posedge clk)
    if (afeValid === 1'h1)
      seen.push_back(afeWrite);
endmodule : afe_model
`default_nettype wire

/* File: sim/modem_config_command_decoder_bench.sv */
/* bench: apb master and front-end log; assumes pready ends each access */
`timescale 1ns/1ps
`default_nettype none
module modem_config_command_decoder_bench import modem_cmd_pkg::*; ;
  logic clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic pready, pslverr, afeValid, cmdError, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  afe_write_t afeWrite;
  line_mode_t lineMode;
  fsk_cfg_t fskCfg;
  int errCount = 0, checkCount = 0;
  always #2.5 clk = ~clk;
  modem_config_command_decoder dut_u (.*);
  afe_model model_u (.*);
  initial #20000 reportAndStop(1);
  task chk(input logic [31:0] seen, exp);
    checkCount++;
    errCount += (seen !== exp);
    if (seen !== exp) $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, 24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    // let the taking edge settle
    #1;
  endtask : apb
  task automatic afeTest;
    logic [7:0] b [6] = '{8'h07, 8'ha0, 8'h5c, 8'h07, 8'h60, 8'h3a};
    foreach (b[i]) apb(1'h1, ADDR_CMD, b[i]);
    repeat (3) @(posedge clk);
    chk(model_u.seen.size(), 2);
    chk(model_u.seen[0], 11'h55c);
    chk(model_u.seen[1], 11'h33a);
  endtask : afeTest
  task automatic fskTest;
    logic [7:0] p1 [3] = '{8'h08, 8'h03, 8'h0d};
    logic [7:0] p2 [3] = '{8'h92, 8'h50, 8'hf2};
    for (int s = 0; s < 3; s++)
    begin
      apb(1'h1, ADDR_CMD, OP_FSK_CFG);
      apb(1'h1, ADDR_CMD, p1[s]);
      apb(1'h1, ADDR_CMD, p2[s]);
      chk(lineMode, MODE_FSK);
      chk(fskCfg, {p1[s][3:0], p2[s][7:4], p2[s][1]});
    end
  endtask : fskTest
  task automatic v22Test;
    line_mode_t want [4] = '{MODE_V22BIS, MODE_V22, MODE_V22_600, MODE_BELL212};
    for (int m = 0; m < 4; m++)
    begin
      apb(1'h1, ADDR_CMD, OP_V22_CFG);
      apb(1'h1, ADDR_CMD, {5'h00, m[1:0], 1'h0});
      chk(lineMode, want[m]);
    end
    apb(1'h0, 12'hff0, 8'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
  endtask : v22Test
  task automatic errTest;
    apb(1'h1, ADDR_CMD, 8'h55);
    chk(cmdError, 1'h1);
    apb(1'h0, ADDR_STATUS, 8'h00);
    chk(rd, {26'h0, 1'h1, MODE_BELL212, 2'h0});
    chk(cmdError, 1'h0);
    apb(1'h1, ADDR_CMD, OP_V22_CFG);
    apb(1'h1, ADDR_CMD, 8'h00);
    chk(lineMode, MODE_V22BIS);
  endtask : errTest
  task reportAndStop(input int extra);
    errCount += extra;
    $display("checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : reportAndStop
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    afeTest();
    fskTest();
    v22Test();
    errTest();
    reportAndStop(0);
  end
endmodule : modem_config_command_decoder_bench
`default_nettype wire
